// *** hdl/rtc_cfg.svh ***
// Register offsets, field positions and reset values of the wheel bank
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define RTC_OFS_FAULT      8'h01
`define RTC_OFS_POSITION   8'h02
`define RTC_OFS_CONFIG     8'h03
`define RTC_OFS_SENS       8'h04

`define RTC_CFG_FN_EN_BIT   0
`define RTC_CFG_TOUCH_BIT   2
`define RTC_CFG_REL_BIT     3
`define RTC_CFG_CLICK_BIT   7
`define RTC_CFG_RW_MASK     8'h8d

`define RTC_POS_ACTIVE_BIT  4
`define RTC_EVT_TOUCH_BASE  8'h10
`define RTC_EVT_RELEASE     8'h0f

`define RTC_RST_CONFIG      8'h00
`define RTC_RST_SENS        3'h0
`define RTC_RST_PTR         8'h00

`define RTC_I2C_BITS        4'h8

`endif

// *** hdl/rtc_pkg.sv ***
// Types shared by the wheel register bank
`default_nettype none
package rtc_pkg;

    typedef struct packed {
        logic [1:0] fault;
        logic       active;
        logic [3:0] pos;
    } rtc_sense_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } rtc_evt_t;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0010,
        ST_PTR       = 4'b0011,
        ST_PTR_ACK   = 4'b0100,
        ST_WDATA     = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA     = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } rtc_state_t;

endpackage : rtc_pkg
`default_nettype wire

// *** hdl/rtc_sync.sv ***
// Two-flop synchroniser, one stage pair per bit
`default_nettype none
module rtc_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Idle-high bus lines, so reset to one
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[i]   <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    meta_q[i]   <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule : rtc_sync
`default_nettype wire

// *** hdl/rtc_regs.sv ***
// Wheel status and configuration bank behind a two-wire slave port
`include "rtc_cfg.svh"
`default_nettype none
// Contract
// RULE_01: Fault bits 1-0 give 00 clean, 01 supply short, 10 ground short.
// RULE_02: Position reads 0 in bits 7-5, touch in bit 4, index in bits 3-0.
// RULE_03: Writes to the position register are ignored and change nothing.
// RULE_04: Position reads all zero when released or when the wheel is off.
// RULE_05: Touched: bit 4 set, bits 3-0 count clockwise from 0 north to 15.
// RULE_06: Config bit 0 enables the wheel function; clear disables it fully.
// RULE_07: Config bit 2 queues each touch as event code 0x10 plus position.
// RULE_08: Config bit 3 queues each release as event code 0x0f.
// RULE_09: Config bit 7 makes each touch fire a sounder click, else none.
// RULE_10: Config bits 6, 5, 4 and 1 read as zero and ignore written values.
// RULE_11: Sensitivity: 3-bit level in bits 2-0, upper write bits ignored.
// RULE_12: Host access drops the interrupt; it re-arms once the queue empties.
// RULE_13: Touch, release and click settings act only while the wheel is on.
module rtc_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary slave address
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe,
    input  wire rtc_pkg::rtc_sense_t sense,
    input  wire logic               fifo_empty,
    output rtc_pkg::rtc_evt_t       evt,
    output logic                    click,
    output logic                    irq_n,
    output logic                    wheel_function_enable,
    output logic [2:0]              sens_level
);
    logic [1:0]          bus_s;
    logic                scl_s;
    logic                sda_s;
    logic                scl_p_q;
    logic                sda_p_q;
    rtc_pkg::rtc_state_t st_q;
    logic [3:0]          cnt_q;
    logic [7:0]          sh_q;
    logic [7:0]          tx_q;
    logic [7:0]          ptr_q;
    logic                rw_q;
    logic                nack_q;
    logic                drive_q;
    logic [7:0]          cfg_q;
    logic [2:0]          sens_q;
    logic                prev_act_q;
    logic [3:0]          prev_pos_q;
    logic                irq_q;
    logic                armed_q;

    rtc_sync #(.WIDTH(2)) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({scl_i, sda_i}),
        .sync_out (bus_s)
    );
    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];

    // Bus line events, all from synchronised copies
    wire scl_rise  = scl_s & ~scl_p_q;
    wire scl_fall  = ~scl_s & scl_p_q;
    wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire byte_done = scl_fall & (cnt_q == `RTC_I2C_BITS);
    wire addr_hit  = (sh_q[7:1] == DEV_ADDR);
    wire wr_stb    = (st_q == rtc_pkg::ST_WDATA) & byte_done;
    wire access    = (st_q == rtc_pkg::ST_ADDR) & byte_done & addr_hit;

    // Register field views
    wire fn_en   = cfg_q[`RTC_CFG_FN_EN_BIT];                    // [RULE_06]
    wire live    = fn_en & sense.active;                         // [RULE_13]
    wire [7:0] pos_rd = live ? {3'h0, 1'b1, sense.pos}  // [RULE_02] [RULE_05]
                             : 8'h00;                   // [RULE_04]
    wire [7:0] flt_rd = {6'h00, sense.fault};                    // [RULE_01]
    wire [7:0] cfg_rd = cfg_q & `RTC_CFG_RW_MASK;                // [RULE_10]
    wire [7:0] sen_rd = {5'h00, sens_q};                         // [RULE_11]

    wire sel_flt = (ptr_q == `RTC_OFS_FAULT);
    wire sel_pos = (ptr_q == `RTC_OFS_POSITION);
    wire sel_cfg = (ptr_q == `RTC_OFS_CONFIG);
    wire sel_sen = (ptr_q == `RTC_OFS_SENS);
    // Unmapped offsets read as zero
    wire [7:0] rdata = ({8{sel_flt}} & flt_rd) | ({8{sel_pos}} & pos_rd)
                     | ({8{sel_cfg}} & cfg_rd) | ({8{sel_sen}} & sen_rd);

    // Wheel event detection
    wire touch_new = live & (~prev_act_q | (sense.pos != prev_pos_q));
    wire release_e = fn_en & ~sense.active & prev_act_q;
    wire push_t    = touch_new & cfg_q[`RTC_CFG_TOUCH_BIT];      // [RULE_07]
    wire push_r    = release_e & cfg_q[`RTC_CFG_REL_BIT];        // [RULE_08]

    assign sda_o  = 1'b0;
    assign sda_oe = drive_q;
    assign irq_n  = ~irq_q;
    assign wheel_function_enable = fn_en;
    assign sens_level = sens_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Two-wire slave engine; start and stop override every state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= rtc_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            tx_q    <= 8'h00;
            ptr_q   <= `RTC_RST_PTR;
            rw_q    <= 1'b0;
            nack_q  <= 1'b0;
            drive_q <= 1'b0;
        end else if (start_det) begin
            st_q    <= rtc_pkg::ST_ADDR;
            cnt_q   <= 4'h0;
            drive_q <= 1'b0;
        end else if (stop_det) begin
            st_q    <= rtc_pkg::ST_IDLE;
            drive_q <= 1'b0;
        end else begin
            case (st_q)
                rtc_pkg::ST_ADDR, rtc_pkg::ST_PTR, rtc_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        cnt_q <= 4'h0;
                        if (st_q == rtc_pkg::ST_ADDR) begin
                            // Foreign address: stay off the bus
                            if (addr_hit) begin
                                rw_q    <= sh_q[0];
                                drive_q <= 1'b1;
                                st_q    <= rtc_pkg::ST_ADDR_ACK;
                            end else begin
                                st_q <= rtc_pkg::ST_IDLE;
                            end
                        end else if (st_q == rtc_pkg::ST_PTR) begin
                            ptr_q   <= sh_q;
                            drive_q <= 1'b1;
                            st_q    <= rtc_pkg::ST_PTR_ACK;
                        end else begin
                            // Auto-increment so bursts walk the map
                            ptr_q   <= ptr_q + 8'h01;
                            drive_q <= 1'b1;
                            st_q    <= rtc_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                rtc_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            tx_q    <= {rdata[6:0], 1'b0};
                            drive_q <= ~rdata[7];
                            ptr_q   <= ptr_q + 8'h01;
                            st_q    <= rtc_pkg::ST_RDATA;
                        end else begin
                            drive_q <= 1'b0;
                            st_q    <= rtc_pkg::ST_PTR;
                        end
                    end
                end
                rtc_pkg::ST_PTR_ACK, rtc_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        drive_q <= 1'b0;
                        st_q    <= rtc_pkg::ST_WDATA;
                    end
                end
                rtc_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == 4'h7) begin
                            cnt_q   <= 4'h0;
                            drive_q <= 1'b0;
                            st_q    <= rtc_pkg::ST_RDATA_ACK;
                        end else begin
                            cnt_q   <= cnt_q + 4'h1;
                            drive_q <= ~tx_q[7];
                            tx_q    <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
                rtc_pkg::ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_s;
                    end else if (scl_fall) begin
                        if (!nack_q) begin
                            tx_q    <= {rdata[6:0], 1'b0};
                            drive_q <= ~rdata[7];
                            ptr_q   <= ptr_q + 8'h01;
                            st_q    <= rtc_pkg::ST_RDATA;
                        end else begin
                            st_q <= rtc_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    drive_q <= 1'b0;
                    cnt_q   <= 4'h0;
                end
            endcase
        end
    end

    // Writable fields; fault and position offsets take no write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q  <= `RTC_RST_CONFIG;
            sens_q <= `RTC_RST_SENS;
        end else if (wr_stb) begin
            if (sel_cfg) begin
                cfg_q <= sh_q & `RTC_CFG_RW_MASK;  // [RULE_06] [RULE_10]
            end
            if (sel_sen) begin
                sens_q <= sh_q[2:0];               // [RULE_11]
            end
        end                                        // [RULE_03]
    end

    // Track last reported touch; disabled function forgets it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_act_q <= 1'b0;
            prev_pos_q <= 4'h0;
        end else begin
            prev_act_q <= live;                    // [RULE_13]
            prev_pos_q <= sense.pos;
        end
    end

    // Queue push and click strobes, one cycle each
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt   <= '0;
            click <= 1'b0;
        end else begin
            evt.valid <= push_t | push_r;
            evt.code  <= push_t ? (`RTC_EVT_TOUCH_BASE | {4'h0, sense.pos})
                                : `RTC_EVT_RELEASE;  // [RULE_07] [RULE_08]
            click <= touch_new & cfg_q[`RTC_CFG_CLICK_BIT];     // [RULE_09]
        end
    end

    // Access drops the line and disarms until the queue is drained
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q   <= 1'b0;
            armed_q <= 1'b1;
        end else begin
            if (access) begin
                armed_q <= 1'b0;                                // [RULE_12]
            end else if (fifo_empty) begin
                armed_q <= 1'b1;                                // [RULE_12]
            end
            if ((push_t | push_r) & armed_q & ~access) begin
                irq_q <= 1'b1;
            end else if (access) begin
                irq_q <= 1'b0;                                  // [RULE_12]
            end
        end
    end

endmodule : rtc_regs
`default_nettype wire

// *** verification/rtc_regs_checker.sv ***
// Port assertions for the wheel register bank
`default_nettype none
module rtc_regs_checker (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                sda_oe,
    input wire rtc_pkg::rtc_sense_t sense,
    input wire rtc_pkg::rtc_evt_t   evt,
    input wire logic                click,
    input wire logic                irq_n,
    input wire logic                wheel_function_enable,
    input wire logic [2:0]          sens_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Settings land with the byte's acknowledge
    sequence s_ack;
        ##[0:6] sda_oe;
    endsequence
    sequence s_rel;
        evt.code[4:0] == 5'h0f && $past(sense.active, 2) && !$past(sense.active);
    endsequence
    property p_off;
        !wheel_function_enable |=> !evt.valid && !click;
    endproperty
    a_off: assert property (p_off)
        else $error("output while off");
    property p_gate;
        evt.valid || click |-> $past(wheel_function_enable);
    endproperty
    a_gate: assert property (p_gate)
        else $error("output without enable");
    property p_tch;
        evt.valid && evt.code[4] |-> evt.code[3:0] == $past(sense.pos)
            && $past(sense.active) && (!click || $past(sense.active));
    endproperty
    a_tch: assert property (p_tch)
        else $error("touch code");
    property p_rel; evt.valid && !evt.code[4] |-> s_rel; endproperty
    a_rel: assert property (p_rel)
        else $error("release code");
    property p_irq; $fell(irq_n) |-> evt.valid; endproperty
    a_irq: assert property (p_irq)
        else $error("irq without push");
    property p_clr; $rose(sda_oe) |-> ##[0:6] irq_n; endproperty
    a_clr: assert property (p_clr)
        else $error("irq not cleared");
    property p_en; $changed(wheel_function_enable) |-> s_ack; endproperty
    a_en: assert property (p_en)
        else $error("enable moved");
    property p_sn; $changed(sens_level) |-> s_ack; endproperty
    a_sn: assert property (p_sn)
        else $error("level moved");
endmodule : rtc_regs_checker
bind rtc_regs rtc_regs_checker chk (.mclk(mclk), .rst_n(rst_n),
    .sda_oe(sda_oe), .sense(sense), .evt(evt), .click(click),
    .irq_n(irq_n), .wheel_function_enable(wheel_function_enable),
    .sens_level(sens_level));
`default_nettype wire

// *** verification/rtc_host_model.sv ***
// Two-wire bus master standing in for the host
`default_nettype none
module rtc_host_model (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    // Six cycles a phase, clear of the four-cycle minimum
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        tick(6);
        scl = 1'b1;
        tick(3);
        r = sda;
        tick(3);
        scl = 1'b0;
        tick(1);
    endtask : bit_io
    task automatic start;
        sda_low = 1'b0;
        tick(6);
        scl = 1'b1;
        tick(6);
        sda_low = 1'b1;
        tick(6);
        scl = 1'b0;
        tick(1);
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        tick(6);
        scl = 1'b1;
        tick(6);
        sda_low = 1'b0;
        tick(6);
    endtask : stop
    task automatic xfer(input logic [7:0] tx, input logic ak,
                        output logic [7:0] rx, output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ak, ao);
    endtask : xfer
endmodule : rtc_host_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the wheel register bank
`include "rtc_cfg.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] ADDR = 7'h2a; // Arbitrary slave address
    logic                mclk, rst_n, scl, sda_low, sda_o, sda_oe;
    logic                fifo_empty, click, irq_n, en;
    logic [2:0]          sens_level;
    rtc_pkg::rtc_sense_t sense;
    rtc_pkg::rtc_evt_t   evt;
    int                  fails, samples_checked, n_evt, n_clk;
    logic [7:0]          last;
    // Open drain with pull-up
    wire logic sda = !(sda_low || (sda_oe && !sda_o));
    rtc_regs #(.DEV_ADDR(ADDR)) dut (.mclk(mclk), .rst_n(rst_n),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .sense(sense), .fifo_empty(fifo_empty), .evt(evt),
        .click(click), .irq_n(irq_n), .wheel_function_enable(en),
        .sens_level(sens_level));
    rtc_host_model host (.mclk(mclk), .sda(sda), .scl(scl),
        .sda_low(sda_low));
    always @(posedge mclk) begin
        if (evt.valid === 1'b1) begin
            n_evt++;
            last = evt.code;
        end
        if (click === 1'b1) n_clk++;
    end
    task automatic ck(input string w, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : ck
    task automatic wr(input logic [7:0] o, d);
        logic [7:0] r;
        logic a, b, c;
        host.start();
        host.xfer({ADDR, 1'b0}, 1'b1, r, a);
        host.xfer(o, 1'b1, r, b);
        host.xfer(d, 1'b1, r, c);
        host.stop();
        ck("write ack", 8'h00, {5'h00, a, b, c});
    endtask : wr
    task automatic rc(input logic [7:0] o, e);
        logic [7:0] r, d;
        logic a, b, c;
        host.start();
        host.xfer({ADDR, 1'b0}, 1'b1, r, a);
        host.xfer(o, 1'b1, r, b);
        host.start();
        host.xfer({ADDR, 1'b1}, 1'b1, r, c);
        host.xfer(8'hff, 1'b1, d, a);
        host.stop();
        ck("read", e, d);
        ck("read ack", 8'h00, {6'h00, b, c});
    endtask : rc
    task automatic tp(input logic a, input logic [3:0] p);
        sense.active = a;
        sense.pos = p;
        host.tick(3);
    endtask : tp
    task automatic t_cfg;
        rc(`RTC_OFS_CONFIG, 8'h00);
        ck("irq idle", 8'h01, {7'h00, irq_n});
        for (int f = 0; f < 3; f++) begin
            sense.fault = f[1:0];
            rc(`RTC_OFS_FAULT, {6'h00, f[1:0]});
        end
        wr(`RTC_OFS_CONFIG, 8'hff);
        rc(`RTC_OFS_CONFIG, 8'h8d);
        ck("enable", 8'h01, {7'h00, en});
    endtask : t_cfg
    task automatic t_pos;
        int e;
        e = n_evt;
        for (int p = 0; p < 16; p++) begin
            tp(1'b1, p[3:0]);
            ck("touch code", {4'h1, p[3:0]}, last);
            rc(`RTC_OFS_POSITION, {4'h1, p[3:0]});
        end
        ck("clicks", 8'd16, 8'(n_clk));
        wr(`RTC_OFS_POSITION, 8'h55);
        rc(`RTC_OFS_POSITION, 8'h1f);
        rc(`RTC_OFS_CONFIG, 8'h8d);
        tp(1'b0, 4'h0);
        ck("release code", 8'h0f, last);
        ck("events", 8'd17, 8'(n_evt - e));
        rc(`RTC_OFS_POSITION, 8'h00);
    endtask : t_pos
    task automatic t_gate;
        int e, c;
        e = n_evt;
        c = n_clk;
        wr(`RTC_OFS_CONFIG, 8'h01);
        tp(1'b1, 4'h3);
        rc(`RTC_OFS_POSITION, 8'h13);
        tp(1'b0, 4'h3);
        wr(`RTC_OFS_CONFIG, 8'h8c);
        tp(1'b1, 4'h6);
        rc(`RTC_OFS_POSITION, 8'h00);
        tp(1'b0, 4'h6);
        ck("gated", 8'h00, 8'((n_evt - e) + (n_clk - c)));
    endtask : t_gate
    task automatic t_sens;
        for (int c = 0; c < 7; c++) begin
            wr(`RTC_OFS_SENS, {5'h1f, c[2:0]});
            rc(`RTC_OFS_SENS, {5'h00, c[2:0]});
            ck("level", {5'h00, c[2:0]}, {5'h00, sens_level});
        end
    endtask : t_sens
    task automatic t_irq;
        wr(`RTC_OFS_CONFIG, 8'h8d);
        tp(1'b1, 4'h7);
        ck("irq set", 8'h00, {7'h00, irq_n});
        fifo_empty = 1'b0;
        rc(`RTC_OFS_POSITION, 8'h17);
        ck("irq clear", 8'h01, {7'h00, irq_n});
        tp(1'b1, 4'h8);
        ck("irq held", 8'h01, {7'h00, irq_n});
        fifo_empty = 1'b1;
        host.tick(4);
        tp(1'b1, 4'h9);
        ck("irq again", 8'h00, {7'h00, irq_n});
        wr(`RTC_OFS_POSITION, 8'h00);
        ck("irq wr clear", 8'h01, {7'h00, irq_n});
    endtask : t_irq
    task automatic complete_run;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (80000) @(posedge mclk);
        fails++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        fifo_empty = 1'b1;
        sense = '0;
        repeat (4) @(posedge mclk);
        #1 rst_n = 1'b1;
        host.tick(3);
        t_cfg();
        t_pos();
        t_gate();
        t_sens();
        t_irq();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
